// ### logic/dsd_pkg.sv
/*
  Constants for the service identifier decoder: encoding codes, value
  limits, register offsets and reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dsd_pkg;
  // Encoding codes
  localparam logic [7:0] TYPE_CONT   = 8'h32;
  localparam logic [7:0] SUB_ID      = 8'h01;
  localparam logic [7:0] SUB_ACT     = 8'h02;
  localparam logic [7:0] SUB_RSQ     = 8'h03;
  localparam logic [7:0] SUB_MC      = 8'h04;
  localparam logic [7:0] RS_FLAG     = 8'h01;
  localparam logic [7:0] RS_CH       = 8'h02;
  localparam logic [7:0] RS_WAIT     = 8'h03;
  localparam logic [7:0] RS_THR      = 8'h04;
  localparam logic [7:0] RS_HOLD     = 8'h05;
  localparam logic [7:0] RS_RLD      = 8'h06;
  // Fixed value lengths, zero meaning variable
  localparam logic [7:0] LEN_ID      = 8'h03;
  localparam logic [7:0] LEN_ONE     = 8'h01;
  localparam logic [7:0] LEN_HOLD    = 8'h02;
  localparam logic [7:0] LEN_VAR     = 8'h00;
  // Value limits
  localparam logic [23:0] ID_MAX     = 24'h0fffff;
  localparam logic [7:0] ACT_MAX     = 8'h02;
  localparam logic [7:0] FLAG_ON     = 8'h01;
  localparam logic [7:0] WAIT_MIN    = 8'h01;
  localparam logic [7:0] WAIT_MAX    = 8'hb4;
  localparam logic [7:0] THR_MAX     = 8'hb3;
  localparam logic [7:0] RLD_MAX     = 8'h01;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_BACKOFF = 8'h04;
  localparam logic [7:0] OFS_RCS     = 8'h08;
  localparam logic [7:0] OFS_ID      = 8'h0c;
  localparam logic [7:0] OFS_RSQ     = 8'h10;
  localparam logic [7:0] OFS_HOLD    = 8'h14;
  localparam logic [7:0] OFS_CHAN    = 8'h18;
  localparam logic [7:0] OFS_COUNT   = 8'h1c;
  // Reset values
  localparam logic        RST_ENABLE  = 1'b1;
  localparam logic [15:0] RST_BACKOFF = 16'h0001;

  typedef enum logic [3:0] {
    ST_TT  = 4'h0,
    ST_TLO = 4'h1,
    ST_TSK = 4'h2,
    ST_TLC = 4'h3,
    ST_L1T = 4'h4,
    ST_L1L = 4'h5,
    ST_L1V = 4'h6,
    ST_L2T = 4'h7,
    ST_L2L = 4'h8,
    ST_L2V = 4'h9,
    ST_CSK = 4'ha
  } dsd_state_type;
endpackage : dsd_pkg
`default_nettype wire

// ### logic/dsd_tlv_decoder.sv
/*
  Decoder for downstream service identifier containers in a management
  message byte stream, with an AHB-Lite register slave.
  Assumes the message parser presents one byte per strobe, marks the first
  byte of each message, and that all inputs are on clk.
*/
// The address map and the AHB-Lite slave port were left to the implementer.
// What this block does
// - Every element is type, one-byte length, then value.
// - Several type 50 containers per message, each decoded on its own.
// - Identifier is three bytes, range 1 to 1048575, always present.
// - Action byte: 0 add, 1 change, 2 delete, others reserved; mandatory.
// - Resequencing flag must be 1; other values reserved; mandatory.
// - A present channel list limits loss detection to listed channels.
// - Without channel list, all receive channel set channels apply.
// - Wait time is one byte, 1 to 180, in 100 us units.
// - Missing wait time defaults to the maximum, 180.
// - Missing or zero threshold disables threshold counting and reporting.
// - Hold-off timer is two bytes in 20 ms units.
// - Missing hold-off uses the learned status backoff timer value.
// - Loss detection control byte: 0 disables, 1 enables.
// - Missing loss detection control means detection is enabled.
// - Multicast container contents are passed to the multicast handler.
`timescale 1ns/10ps
`default_nettype none
module dsd_tlv_decoder #(
  parameter int CH_N = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Message byte stream
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  input  wire logic              msg_start,
  // Decoded container
  output logic                   res_done,
  output logic                   res_err,
  output logic [19:0]            res_downstream_service_id,
  output logic [1:0]             res_action,
  output logic                   res_reseq,
  output logic [7:0]             res_wait,
  output logic [7:0]             res_thr,
  output logic                   res_thr_en,
  output logic [15:0]            res_hold,
  output logic                   res_rld_en,
  output logic [CH_N-1:0]        res_ch_mask,
  // Multicast handler
  output logic                   mcast_valid,
  output logic [7:0]             mcast_data,
  output logic                   mcast_last,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp
);
  generate
    if (CH_N < 1 || CH_N > 32) begin : g_bad
      $error("CH_N must lie in 1..32");
    end
  endgenerate

  dsd_pkg::dsd_state_type st_reg, cur_st, st_next;
  logic [7:0]  top_rem_reg, l1_rem_reg, rs_rem_reg, l2_rem_reg, skip_reg;
  logic [7:0]  l1_type_reg, l2_type_reg;
  logic        en_reg;
  logic [15:0] backoff_reg;
  logic [CH_N-1:0] rcs_reg;
  logic        tk, in_cont, cont_last, v1, v2, err_set, fin_reg, bad;
  logic [7:0]  b, exp_len;
  logic [23:0] id_reg;
  logic [7:0]  act_reg, flag_reg, wait_reg, thr_reg, rld_reg;
  logic [15:0] hold_reg;
  logic        id_seen, act_seen, rs_seen, flag_seen, ch_seen;
  logic        wait_seen, thr_seen, hold_seen, rld_seen, err_reg;
  logic [CH_N-1:0] ch_reg, ch_hit;
  logic [15:0] cnt_ok_reg, cnt_err_reg;

  assign b = byte_data;
  assign tk = byte_valid && en_reg;
  // A message start always resynchronises the walk at top level
  assign cur_st = msg_start ? dsd_pkg::ST_TT : st_reg;
  assign in_cont = tk && (cur_st inside {dsd_pkg::ST_L1T, dsd_pkg::ST_L1L, dsd_pkg::ST_L1V,
                   dsd_pkg::ST_L2T, dsd_pkg::ST_L2L, dsd_pkg::ST_L2V, dsd_pkg::ST_CSK});
  assign cont_last = in_cont && (top_rem_reg == 8'h01);
  assign v1 = tk && (cur_st == dsd_pkg::ST_L1V);
  assign v2 = tk && (cur_st == dsd_pkg::ST_L2V);

  always_comb
  begin
    exp_len = dsd_pkg::LEN_VAR;
    if (cur_st == dsd_pkg::ST_L1L)
    begin
      case (l1_type_reg)
        dsd_pkg::SUB_ID:  exp_len = dsd_pkg::LEN_ID;
        dsd_pkg::SUB_ACT: exp_len = dsd_pkg::LEN_ONE;
        default:          exp_len = dsd_pkg::LEN_VAR;
      endcase
    end
    else
    begin
      case (l2_type_reg)
        dsd_pkg::RS_FLAG, dsd_pkg::RS_WAIT,
        dsd_pkg::RS_THR, dsd_pkg::RS_RLD: exp_len = dsd_pkg::LEN_ONE;
        dsd_pkg::RS_HOLD:                 exp_len = dsd_pkg::LEN_HOLD;
        default:                          exp_len = dsd_pkg::LEN_VAR;
      endcase
    end
  end

  // Next state; the last byte of a container always returns to top level
  always_comb
  begin
    st_next = cur_st;
    err_set = 1'b0;
    case (cur_st)
      dsd_pkg::ST_TT:  st_next = (b == dsd_pkg::TYPE_CONT) ? dsd_pkg::ST_TLC
                                                           : dsd_pkg::ST_TLO;
      dsd_pkg::ST_TLO: st_next = (b == 8'h00) ? dsd_pkg::ST_TT : dsd_pkg::ST_TSK;
      dsd_pkg::ST_TSK: st_next = (skip_reg == 8'h01) ? dsd_pkg::ST_TT : dsd_pkg::ST_TSK;
      dsd_pkg::ST_TLC: st_next = (b == 8'h00) ? dsd_pkg::ST_TT : dsd_pkg::ST_L1T;
      dsd_pkg::ST_L1T:
      begin
        st_next = dsd_pkg::ST_L1L;
        err_set = cont_last;
      end
      dsd_pkg::ST_L1L:
      begin
        if (b > top_rem_reg - 8'h01)
        begin
          st_next = dsd_pkg::ST_CSK;
          err_set = 1'b1;
        end
        else
        begin
          err_set = (exp_len != dsd_pkg::LEN_VAR) && (b != exp_len);
          if (b == 8'h00)
            st_next = dsd_pkg::ST_L1T;
          else if (l1_type_reg == dsd_pkg::SUB_RSQ)
            st_next = dsd_pkg::ST_L2T;
          else
            st_next = dsd_pkg::ST_L1V;
        end
      end
      dsd_pkg::ST_L1V: st_next = (l1_rem_reg == 8'h01) ? dsd_pkg::ST_L1T : dsd_pkg::ST_L1V;
      dsd_pkg::ST_L2T:
      begin
        st_next = (rs_rem_reg == 8'h01) ? dsd_pkg::ST_L1T : dsd_pkg::ST_L2L;
        err_set = (rs_rem_reg == 8'h01);
      end
      dsd_pkg::ST_L2L:
      begin
        if (b > rs_rem_reg - 8'h01)
        begin
          st_next = dsd_pkg::ST_CSK;
          err_set = 1'b1;
        end
        else
        begin
          err_set = (exp_len != dsd_pkg::LEN_VAR) && (b != exp_len);
          if (b != 8'h00)
            st_next = dsd_pkg::ST_L2V;
          else
            st_next = (rs_rem_reg == 8'h01) ? dsd_pkg::ST_L1T : dsd_pkg::ST_L2T;
        end
      end
      dsd_pkg::ST_L2V:
        if (l2_rem_reg == 8'h01)
          st_next = (rs_rem_reg == 8'h01) ? dsd_pkg::ST_L1T : dsd_pkg::ST_L2T;
      dsd_pkg::ST_CSK: st_next = dsd_pkg::ST_CSK;
      default:         st_next = dsd_pkg::ST_TT;
    endcase
    if (cont_last)
      st_next = dsd_pkg::ST_TT;
  end

  // Walk state and remaining-length counters
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg      <= dsd_pkg::ST_TT;
      top_rem_reg <= 8'h00;
      l1_rem_reg  <= 8'h00;
      rs_rem_reg  <= 8'h00;
      l2_rem_reg  <= 8'h00;
      skip_reg    <= 8'h00;
      l1_type_reg <= 8'h00;
      l2_type_reg <= 8'h00;
    end
    else if (tk)
    begin
      st_reg <= st_next;
      if (in_cont)
        top_rem_reg <= top_rem_reg - 8'h01;
      case (cur_st)
        dsd_pkg::ST_TLO: skip_reg <= b;
        dsd_pkg::ST_TSK: skip_reg <= skip_reg - 8'h01;
        dsd_pkg::ST_TLC: top_rem_reg <= b;
        dsd_pkg::ST_L1T: l1_type_reg <= b;
        dsd_pkg::ST_L1L:
        begin
          l1_rem_reg <= b;
          rs_rem_reg <= b;
        end
        dsd_pkg::ST_L1V: l1_rem_reg <= l1_rem_reg - 8'h01;
        dsd_pkg::ST_L2T:
        begin
          l2_type_reg <= b;
          rs_rem_reg  <= rs_rem_reg - 8'h01;
        end
        dsd_pkg::ST_L2L:
        begin
          l2_rem_reg <= b;
          rs_rem_reg <= rs_rem_reg - 8'h01;
        end
        dsd_pkg::ST_L2V:
        begin
          l2_rem_reg <= l2_rem_reg - 8'h01;
          rs_rem_reg <= rs_rem_reg - 8'h01;
        end
        default: skip_reg <= skip_reg;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      assign ch_hit[gi] = v2 && (l2_type_reg == dsd_pkg::RS_CH) && (b == 8'(gi));
    end
  endgenerate

  // Captured fields of the container under decode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {id_seen, act_seen, rs_seen, flag_seen, ch_seen} <= 5'h00;
      {wait_seen, thr_seen, hold_seen, rld_seen, err_reg} <= 5'h00;
      id_reg <= 24'h000000;
      {act_reg, flag_reg, wait_reg, thr_reg, rld_reg} <= 40'h0000000000;
      hold_reg <= 16'h0000;
      ch_reg <= '0;
    end
    else if (tk && cur_st == dsd_pkg::ST_TLC)
    begin
      {id_seen, act_seen, rs_seen, flag_seen, ch_seen} <= 5'h00;
      {wait_seen, thr_seen, hold_seen, rld_seen, err_reg} <= 5'h00;
      ch_reg <= '0;
    end
    else if (tk)
    begin
      err_reg <= err_reg | err_set;
      ch_reg  <= ch_reg | ch_hit;
      if (cur_st == dsd_pkg::ST_L1L && l1_type_reg == dsd_pkg::SUB_RSQ)
        rs_seen <= 1'b1;
      if (v1 && l1_type_reg == dsd_pkg::SUB_ID)
      begin
        id_reg  <= {id_reg[15:0], b};
        id_seen <= 1'b1;
      end
      if (v1 && l1_type_reg == dsd_pkg::SUB_ACT)
      begin
        act_reg  <= b;
        act_seen <= 1'b1;
      end
      if (v2)
      begin
        case (l2_type_reg)
          dsd_pkg::RS_FLAG: {flag_seen, flag_reg} <= {1'b1, b};
          dsd_pkg::RS_CH:   ch_seen <= 1'b1;
          dsd_pkg::RS_WAIT: {wait_seen, wait_reg} <= {1'b1, b};
          dsd_pkg::RS_THR:  {thr_seen, thr_reg} <= {1'b1, b};
          dsd_pkg::RS_HOLD: {hold_seen, hold_reg} <= {1'b1, hold_reg[7:0], b};
          dsd_pkg::RS_RLD:  {rld_seen, rld_reg} <= {1'b1, b};
          default:          ch_seen <= ch_seen;
        endcase
      end
    end
  end

  assign bad = err_reg || !id_seen || !act_seen
    || id_reg == 24'h000000 || id_reg > dsd_pkg::ID_MAX || act_reg > dsd_pkg::ACT_MAX
    || (rs_seen && (!flag_seen || flag_reg != dsd_pkg::FLAG_ON
    || (wait_seen && (wait_reg < dsd_pkg::WAIT_MIN || wait_reg > dsd_pkg::WAIT_MAX))
    || (thr_seen && thr_reg > dsd_pkg::THR_MAX)
    || (rld_seen && rld_reg > dsd_pkg::RLD_MAX)));

  // Result registers, loaded one cycle after the container's last byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fin_reg <= 1'b0;
      {res_done, res_err, res_reseq, res_thr_en, res_rld_en} <= 5'h00;
      res_downstream_service_id <= 20'h00000;
      res_action <= 2'h0;
      {res_wait, res_thr} <= 16'h0000;
      res_hold <= 16'h0000;
      res_ch_mask <= '0;
      cnt_ok_reg <= 16'h0000;
      cnt_err_reg <= 16'h0000;
    end
    else
    begin
      fin_reg  <= cont_last || (tk && cur_st == dsd_pkg::ST_TLC && b == 8'h00);
      res_done <= fin_reg;
      if (fin_reg)
      begin
        res_err    <= bad;
        res_downstream_service_id   <= id_reg[19:0];
        res_action <= act_reg[1:0];
        res_reseq  <= rs_seen;
        res_wait   <= !rs_seen ? 8'h00 : wait_seen ? wait_reg : dsd_pkg::WAIT_MAX;
        res_thr    <= thr_seen ? thr_reg : 8'h00;
        res_thr_en <= rs_seen && thr_seen && thr_reg != 8'h00;
        res_hold   <= hold_seen ? hold_reg : backoff_reg;
        res_rld_en <= rs_seen && (!rld_seen || rld_reg[0]);
        res_ch_mask <= ch_seen ? ch_reg : rcs_reg;
        if (bad)
          cnt_err_reg <= cnt_err_reg + 16'h0001;
        else
          cnt_ok_reg <= cnt_ok_reg + 16'h0001;
      end
    end
  end

  // Multicast contents pass straight through, one byte per strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mcast_valid <= 1'b0;
      mcast_data  <= 8'h00;
      mcast_last  <= 1'b0;
    end
    else
    begin
      mcast_valid <= v1 && l1_type_reg == dsd_pkg::SUB_MC;
      mcast_data  <= b;
      mcast_last  <= v1 && l1_type_reg == dsd_pkg::SUB_MC && l1_rem_reg == 8'h01;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic       ap;
  assign ap = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= ap && hwrite;
      wr_addr_reg <= haddr[7:0];
      if (ap && !hwrite)
      begin
        case (haddr[7:0])
          dsd_pkg::OFS_CTRL:    hrdata <= {31'h00000000, en_reg};
          dsd_pkg::OFS_BACKOFF: hrdata <= {16'h0000, backoff_reg};
          dsd_pkg::OFS_RCS:     hrdata <= 32'(rcs_reg);
          dsd_pkg::OFS_ID:      hrdata <= {res_err, 5'h00, res_action, 4'h0, res_downstream_service_id};
          dsd_pkg::OFS_RSQ:     hrdata <= {13'h0000, res_reseq, res_thr_en, res_rld_en,
                                           res_thr, res_wait};
          dsd_pkg::OFS_HOLD:    hrdata <= {16'h0000, res_hold};
          dsd_pkg::OFS_CHAN:    hrdata <= 32'(res_ch_mask);
          dsd_pkg::OFS_COUNT:   hrdata <= {cnt_err_reg, cnt_ok_reg};
          default:              hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_reg      <= dsd_pkg::RST_ENABLE;
      backoff_reg <= dsd_pkg::RST_BACKOFF;
      rcs_reg     <= '1;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        dsd_pkg::OFS_CTRL:    en_reg <= hwdata[0];
        dsd_pkg::OFS_BACKOFF: backoff_reg <= hwdata[15:0];
        dsd_pkg::OFS_RCS:     rcs_reg <= hwdata[CH_N-1:0];
        default:              en_reg <= en_reg;
      endcase
    end
  end

  // Checks
  done_after_last_a: assert property (@(posedge clk) disable iff (!resetn)
    cont_last |=> ##1 res_done) else $error("no result after container end");
  downstream_service_id_range_a: assert property (@(posedge clk) disable iff (!resetn)
    res_done && !res_err |-> res_downstream_service_id != 20'h00000) else $error("bad identifier");
  action_code_a: assert property (@(posedge clk) disable iff (!resetn)
    res_done && !res_err |-> res_action <= 2'h2) else $error("reserved action");
  wait_range_a: assert property (@(posedge clk) disable iff (!resetn)
    res_done && !res_err && res_reseq |-> res_wait inside {[8'h01:8'hb4]})
    else $error("wait time out of range");
  wait_default_a: assert property (@(posedge clk) disable iff (!resetn)
    fin_reg && rs_seen && !wait_seen |=> res_wait == 8'hb4)
    else $error("wait default wrong");
  thr_enable_a: assert property (@(posedge clk) disable iff (!resetn)
    res_done |-> res_thr_en == (res_reseq && res_thr != 8'h00))
    else $error("threshold enable wrong");
  hold_default_a: assert property (@(posedge clk) disable iff (!resetn)
    fin_reg && !hold_seen |=> res_hold == $past(backoff_reg))
    else $error("hold-off default wrong");
  rld_default_a: assert property (@(posedge clk) disable iff (!resetn)
    fin_reg && rs_seen && !rld_seen |=> res_rld_en) else $error("detection off");
  chan_default_a: assert property (@(posedge clk) disable iff (!resetn)
    fin_reg && !ch_seen |=> res_ch_mask == $past(rcs_reg))
    else $error("channel default wrong");
  mcast_pass_a: assert property (@(posedge clk) disable iff (!resetn)
    v1 && l1_type_reg == 8'h04 |=> mcast_valid && mcast_data == $past(byte_data))
    else $error("multicast byte lost");
  overrun_err_a: assert property (@(posedge clk) disable iff (!resetn)
    tk && cur_st == dsd_pkg::ST_L1L && b > top_rem_reg - 8'h01 |=> err_reg)
    else $error("length overrun not flagged");

  reseq_ok_c: cover property (@(posedge clk) disable iff (!resetn)
    res_done && !res_err && res_reseq);
  plain_ok_c: cover property (@(posedge clk) disable iff (!resetn)
    res_done && !res_err && !res_reseq);
  invalid_c: cover property (@(posedge clk) disable iff (!resetn) res_done && res_err);
  mcast_c: cover property (@(posedge clk) disable iff (!resetn) mcast_valid && mcast_last);
endmodule : dsd_tlv_decoder
`default_nettype wire

// ### tb/dsd_headend_model.sv
/*
  Headend model: sends management message bytes to the decoder.
  Assumes the bench calls send from one thread, after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module dsd_headend_model (
  // Clock
  input  wire logic       clk,
  // Byte stream
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            msg_start
);
  initial
  begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    msg_start  = 1'b0;
  end

  // Gap models a slow headend; idle data is inverted so stale bytes never look fresh
  task automatic send(input logic [7:0] m [$], input int gap);
    for (int i = 0; i < m.size(); i++)
    begin
      @(posedge clk);
      byte_valid <= 1'b1;
      byte_data  <= m[i];
      msg_start  <= (i == 0);
      repeat (gap)
      begin
        @(posedge clk);
        byte_valid <= 1'b0;
        msg_start  <= 1'b0;
        byte_data  <= ~m[i];
      end
    end
    @(posedge clk);
    byte_valid <= 1'b0;
    msg_start  <= 1'b0;
    byte_data  <= ~byte_data;
  endtask : send
endmodule : dsd_headend_model
`default_nettype wire

// ### tb/dsd_tlv_decoder_tb_top.sv
/*
  Bench for the identifier decoder: registers over AHB-Lite, containers
  from the headend model, results compared with worked-out values.
  Assumes the design's own assertions guard its cycle timing.
*/
`timescale 1ns/10ps
`default_nettype none
module dsd_tlv_decoder_tb_top;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        byte_valid, msg_start, res_done, res_err, res_reseq;
  logic        res_thr_en, res_rld_en, mcast_valid, mcast_last, hreadyout, hresp;
  logic [7:0]  byte_data, res_wait, res_thr, mcast_data, mc_d;
  logic [19:0] res_downstream_service_id;
  logic [1:0]  res_action;
  logic [15:0] res_hold;
  logic [31:0] res_ch_mask, hrdata, rd;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic [31:0] snap [32];
  logic [7:0]  q [$];
  int          err_count = 0;
  int          checks = 0;
  int          n_done = 0;
  int          n_mc = 0;
  int          n_last = 0;
  int          cyc = 0;
  // Id, action, flag, wait, expected error
  logic [55:0] tbl [7] = '{56'h000005_03_01_0a_01, 56'h000000_00_01_0a_01,
                           56'h100000_00_01_0a_01, 56'h000005_00_02_0a_01,
                           56'h000005_00_01_b5_01, 56'h000005_00_01_b4_00,
                           56'h000005_01_01_01_00};

  always #5 clk = ~clk;
  assign hready = hreadyout;

  dsd_headend_model hm_u (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data),
                          .msg_start(msg_start));

  dsd_tlv_decoder #(.CH_N(32)) dut_u (
    .clk(clk), .resetn(resetn), .byte_valid(byte_valid), .byte_data(byte_data),
    .msg_start(msg_start), .res_done(res_done), .res_err(res_err), .res_downstream_service_id(res_downstream_service_id),
    .res_action(res_action), .res_reseq(res_reseq), .res_wait(res_wait),
    .res_thr(res_thr), .res_thr_en(res_thr_en), .res_hold(res_hold),
    .res_rld_en(res_rld_en), .res_ch_mask(res_ch_mask), .mcast_valid(mcast_valid),
    .mcast_data(mcast_data), .mcast_last(mcast_last), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  always @(posedge clk)
  begin
    if (res_done === 1'b1)
    begin
      snap[n_done] <= {res_err, res_reseq, 4'h0, res_action, 4'h0, res_downstream_service_id};
      n_done       <= n_done + 1;
    end
    if (mcast_valid === 1'b1)
      n_mc <= n_mc + 1;
    if (mcast_last === 1'b1)
    begin
      n_last <= n_last + 1;
      mc_d   <= mcast_data;
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] v);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'b0, 32'h0, rd);
    chk(rd, e);
  endtask : rdc

  task automatic wd(input int k);
    int t;
    t = 0;
    while (n_done != k && t < 20)
    begin
      @(posedge clk);
      t++;
    end
    chk(n_done, k);
  endtask : wd

  task automatic chk_rsq(input logic [31:0] e1, input logic [31:0] e2, input logic [31:0] e3);
    chk({res_err, res_reseq, res_thr_en, res_rld_en, 2'b00, res_action, 4'h0, res_downstream_service_id}, e1);
    chk({res_hold, res_thr, res_wait}, e2);
    chk(res_ch_mask, e3);
  endtask : chk_rsq

  // Bare resequencing container, every optional field left out
  task automatic s1();
    q = {8'h32, 8'h0d, 8'h01, 8'h03, 8'h00, 8'h12, 8'h34, 8'h02, 8'h01, 8'h00,
         8'h03, 8'h03, 8'h01, 8'h01, 8'h01};
    hm_u.send(q, 0);
  endtask : s1

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rdc(dsd_pkg::OFS_CTRL, 32'h1);
    rdc(dsd_pkg::OFS_BACKOFF, 32'h1);
    rdc(dsd_pkg::OFS_RCS, 32'hffffffff);
    wr(dsd_pkg::OFS_BACKOFF, 32'habcd);
    wr(dsd_pkg::OFS_RCS, 32'hf00f);
    wr(8'h20, 32'hffffffff);
    rdc(8'h20, 32'h0);
    s1();
    wd(1);
    chk_rsq(32'h50001234, 32'habcd00b4, 32'hf00f);
    rdc(dsd_pkg::OFS_ID, 32'h1234);
    rdc(dsd_pkg::OFS_RSQ, 32'h500b4);
    // Plain delete, then a full container with an unknown subtype, slow headend
    q = {8'h32, 8'h08, 8'h01, 8'h03, 8'h0f, 8'hff, 8'hff, 8'h02, 8'h01, 8'h02,
         8'h32, 8'h21, 8'h01, 8'h03, 8'h00, 8'h00, 8'h01, 8'h02, 8'h01, 8'h01,
         8'h07, 8'h01, 8'haa, 8'h03, 8'h14, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02,
         8'h03, 8'h05, 8'h03, 8'h01, 8'h0a, 8'h04, 8'h01, 8'h09, 8'h05, 8'h02,
         8'h01, 8'h02, 8'h06, 8'h01, 8'h00};
    hm_u.send(q, 1);
    wd(3);
    chk(snap[1], 32'h020fffff);
    chk_rsq(32'h61000001, 32'h0102090a, 32'h28);
    rdc(dsd_pkg::OFS_HOLD, 32'h0102);
    rdc(dsd_pkg::OFS_CHAN, 32'h28);
    foreach (tbl[i])
    begin
      q = {8'h32, 8'h10, 8'h01, 8'h03, tbl[i][55:48], tbl[i][47:40], tbl[i][39:32],
           8'h02, 8'h01, tbl[i][31:24], 8'h03, 8'h06, 8'h01, 8'h01, tbl[i][23:16],
           8'h03, 8'h01, tbl[i][15:8]};
      hm_u.send(q, 0);
      wd(4 + i);
      chk({31'h0, res_err}, {24'h0, tbl[i][7:0]});
      if (tbl[i][7:0] == 8'h00)
        chk({24'h0, res_wait}, {24'h0, tbl[i][15:8]});
    end
    q = {8'h32, 8'h0d, 8'h01, 8'h03, 8'h00, 8'h00, 8'h07, 8'h02, 8'h01, 8'h00,
         8'h04, 8'h03, 8'ha1, 8'ha2, 8'ha3};
    hm_u.send(q, 0);
    wd(11);
    chk({n_mc[15:0], n_last[7:0], mc_d}, 32'h000301a3);
    // Bytes are dropped while disabled
    wr(dsd_pkg::OFS_CTRL, 32'h0);
    hm_u.send(q, 0);
    repeat (4) @(posedge clk);
    chk(n_done, 11);
    wr(dsd_pkg::OFS_CTRL, 32'h1);
    // Subtype length runs past its container: rest skipped, container invalid
    q = {8'h32, 8'h05, 8'h01, 8'h09, 8'h00, 8'h00, 8'h01};
    hm_u.send(q, 0);
    wd(12);
    chk({31'h0, res_err}, 32'h1);
    // A new message start abandons the partial container silently
    q = {8'h32, 8'h0d, 8'h01, 8'h03};
    hm_u.send(q, 0);
    s1();
    wd(13);
    rdc(dsd_pkg::OFS_COUNT, 32'h00060007);
    close_out();
  end
endmodule : dsd_tlv_decoder_tb_top
`default_nettype wire
